// file: rtl/fspg_flash_guard.sv
`timescale 1ns/1ps
module fspg_flash_guard import fspg_pkg::*; #(
  parameter int FLASH_BYTES = FSPG_FLASH_BYTES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [FSPG_AXI_AW-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [FSPG_AXI_AW-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic tool_socket_in,
  input wire logic prog_select_voltage_in,
  input wire logic prog_attached_in,
  input wire logic [1:0] prog_pin_in,
  input wire logic [1:0] app_pin_drive_in,
  input wire logic [1:0] app_pin_oe_in,
  output logic [1:0] prog_pin_out,
  output logic [1:0] prog_pin_oe_out,
  output logic [1:0] app_pin_value_out,
  output logic [1:0] prog_mode_out,
  output logic readout_protect_out,
  output logic busy_out
);

  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int MEM_AW = $clog2(FLASH_BYTES);
  localparam logic [16:0] BASE_WIDE = 17'h10000 - 17'(FLASH_BYTES);
  localparam logic [15:0] FLASH_BASE = BASE_WIDE[15:0];
  localparam logic [MEM_AW-1:0] TOP_IDX = MEM_AW'(FLASH_BYTES - 1);
  localparam logic [MEM_AW-1:0] S0_LO = MEM_AW'(FLASH_BYTES - FSPG_SECTOR_BYTES);
  localparam logic [MEM_AW-1:0] S1_LO =
    MEM_AW'(FLASH_BYTES - 2 * FSPG_SECTOR_BYTES);
  localparam logic [MEM_AW-1:0] IDX_ONE = MEM_AW'(1);

  localparam logic [11:0] A_CTRL = {2'h0, FSPG_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_KEY = {2'h0, FSPG_IDX_KEY, 2'h0};
  localparam logic [11:0] A_ADDR = {2'h0, FSPG_IDX_ADDR, 2'h0};
  localparam logic [11:0] A_WDATA = {2'h0, FSPG_IDX_WDATA, 2'h0};
  localparam logic [11:0] A_RDATA = {2'h0, FSPG_IDX_RDATA, 2'h0};
  localparam logic [11:0] A_OPTION = {2'h0, FSPG_IDX_OPTION, 2'h0};
  localparam logic [11:0] A_MODE = {2'h0, FSPG_IDX_MODE, 2'h0};

  // Top nibble picks the sector; sector 2 is whatever lies below
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a[15:12] == 4'hf) begin
      sector_of = 2'd0;
    end else if (a[15:12] == 4'he) begin
      sector_of = 2'd1;
    end else begin
      sector_of = 2'd2;
    end
  endfunction

  // Array size decides which sectors exist at all
  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= FLASH_BASE);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [FSPG_AXI_AW-1:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic [FSPG_AXI_AW-1:0] ar_addr_reg;
  logic ar_pend_reg;
  logic wr_fire;
  logic wr_ctrl, wr_key, wr_addr, wr_wdata, wr_opt;
  logic [31:0] rd_word;
  logic rd_err;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic protect_reg;
  logic done_reg, refused_reg;
  logic strap_taken_reg, icc_reg, tool_reg;
  fspg_mode_t mode_reg;
  fspg_state_t state_reg;
  logic [MEM_AW-1:0] ptr_reg, end_reg;
  logic auto_unprotect_reg;
  logic unlocked;
  logic cmd_write, opt_write, cmd_ok, start_prog, start_sect, start_mass;
  logic start_unprotect, finish;
  logic sector_allowed;
  logic [1:0] tgt_sector;
  logic mem_we;
  logic [7:0] mem_rdata;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_out;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_addr_reg <= '0;
      aw_held_reg <= 1'b0;
      s_axi_awready_out <= 1'b1;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      w_held_reg <= 1'b0;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= FSPG_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr_reg <= s_axi_awaddr_in;
        aw_held_reg <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
        w_held_reg <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= (wr_ctrl || wr_key || wr_addr || wr_wdata ||
                            wr_opt || aw_addr_reg == A_RDATA ||
                            aw_addr_reg == A_MODE) ?
                           FSPG_RESP_OKAY : FSPG_RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // Address decode for writes; byte registers need lane 0
  always_comb begin
    wr_ctrl = 1'b0;
    wr_key = 1'b0;
    wr_addr = 1'b0;
    wr_wdata = 1'b0;
    wr_opt = 1'b0;
    if (!wr_fire) begin
      wr_ctrl = 1'b0;
    end else if (aw_addr_reg == A_CTRL) begin
      wr_ctrl = w_strb_reg[0];
    end else if (aw_addr_reg == A_KEY) begin
      wr_key = w_strb_reg[0];
    end else if (aw_addr_reg == A_ADDR) begin
      wr_addr = 1'b1;
    end else if (aw_addr_reg == A_WDATA) begin
      wr_wdata = w_strb_reg[0];
    end else if (aw_addr_reg == A_OPTION) begin
      wr_opt = w_strb_reg[0];
    end
  end

  // Read decode; protected array reads back zero to the outside
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (ar_addr_reg == A_CTRL) begin
      rd_word[7:0] = {state_reg != FSPG_ST_IDLE, done_reg, refused_reg,
                      5'h00};
    end else if (ar_addr_reg == A_KEY) begin
      rd_word[0] = unlocked;
    end else if (ar_addr_reg == A_ADDR) begin
      rd_word[15:0] = addr_reg;
    end else if (ar_addr_reg == A_WDATA) begin
      rd_word[7:0] = wdata_reg;
    end else if (ar_addr_reg == A_RDATA) begin
      rd_word[7:0] = (protect_reg && mode_reg != FSPG_MODE_IAP) ?
                     8'h00 : mem_rdata;
    end else if (ar_addr_reg == A_OPTION) begin
      rd_word[FSPG_OPT_PROTECT] = protect_reg;
    end else if (ar_addr_reg == A_MODE) begin
      rd_word[1:0] = mode_reg;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ar_addr_reg <= '0;
      ar_pend_reg <= 1'b0;
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= FSPG_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        ar_addr_reg <= s_axi_araddr_in;
        ar_pend_reg <= 1'b1;
        s_axi_arready_out <= 1'b0;
      end
      if (ar_pend_reg) begin
        ar_pend_reg <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_word;
        s_axi_rresp_out <= rd_err ? FSPG_RESP_SLVERR : FSPG_RESP_OKAY;
      end
      if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Mode strap and pin ownership
  // ----------------------------------------
  // Caught once after reset release; the controller must already hold
  // the select line when reset lets go
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_taken_reg <= 1'b0;
      icc_reg <= 1'b0;
      tool_reg <= 1'b0;
      mode_reg <= FSPG_MODE_IAP;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      icc_reg <= prog_select_voltage_in;
      tool_reg <= tool_socket_in;
      mode_reg <= tool_socket_in ? FSPG_MODE_TOOL :
                  prog_select_voltage_in ? FSPG_MODE_ICP : FSPG_MODE_IAP;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prog_mode_out <= FSPG_MODE_IAP;
    end else begin
      prog_mode_out <= mode_reg;
    end
  end

  // Bit 0 is the serial clock pin, bit 1 the serial data pin
  for (genvar p = 0; p < 2; p++) begin : g_pin
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        prog_pin_out[p] <= 1'b0;
        prog_pin_oe_out[p] <= 1'b0;
        app_pin_value_out[p] <= 1'b0;
      end else if (prog_attached_in || icc_reg) begin
        prog_pin_out[p] <= 1'b0;
        prog_pin_oe_out[p] <= 1'b0;
        app_pin_value_out[p] <= 1'b0;
      end else begin
        prog_pin_out[p] <= app_pin_drive_in[p];
        prog_pin_oe_out[p] <= app_pin_oe_in[p];
        app_pin_value_out[p] <= prog_pin_in[p];
      end
    end
  end

  // ----------------------------------------
  // Data registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_reg <= FSPG_ADDR_RESET;
    end else if (wr_addr) begin
      if (w_strb_reg[0]) begin
        addr_reg[7:0] <= w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        addr_reg[15:8] <= w_data_reg[15:8];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wdata_reg <= FSPG_WDATA_RESET;
    end else if (wr_wdata) begin
      wdata_reg <= w_data_reg[7:0];
    end
  end

  // ----------------------------------------
  // Command check
  // ----------------------------------------
  fspg_access_guard u_guard (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .key_wr_in(wr_key),
    .key_in(w_data_reg[7:0]),
    .consume_in(wr_ctrl || wr_opt),
    .unlocked_out(unlocked)
  );

  assign tgt_sector = sector_of(addr_reg);
  assign cmd_write = wr_ctrl && (|w_data_reg[FSPG_CTL_MASS_ERASE:0]);
  assign cmd_ok = unlocked && state_reg == FSPG_ST_IDLE;
  // Application mode never reaches sector 0; protection blocks all
  assign sector_allowed = in_array(addr_reg) && !protect_reg &&
    !(mode_reg == FSPG_MODE_IAP && tgt_sector == 2'd0);
  assign start_mass = cmd_write && cmd_ok && !protect_reg &&
    w_data_reg[FSPG_CTL_MASS_ERASE] && mode_reg != FSPG_MODE_IAP;
  assign start_sect = cmd_write && cmd_ok && sector_allowed &&
    !w_data_reg[FSPG_CTL_MASS_ERASE] && w_data_reg[FSPG_CTL_SECT_ERASE];
  assign start_prog = cmd_write && cmd_ok && sector_allowed &&
    w_data_reg[2:0] == 3'b001;
  assign opt_write = wr_opt && cmd_ok && mode_reg != FSPG_MODE_IAP;
  assign start_unprotect = opt_write && protect_reg &&
    !w_data_reg[FSPG_OPT_PROTECT];
  assign finish = (state_reg == FSPG_ST_PROGRAM) ||
    (state_reg == FSPG_ST_ERASE && ptr_reg == end_reg);

  // ----------------------------------------
  // Program and erase engine
  // ----------------------------------------
  // Erase walks one byte per cycle; slow but keeps one write port
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= FSPG_ST_IDLE;
      ptr_reg <= '0;
      end_reg <= '0;
      auto_unprotect_reg <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      case (state_reg)
        FSPG_ST_IDLE: begin
          if (start_mass || start_unprotect) begin
            state_reg <= FSPG_ST_ERASE;
            ptr_reg <= '0;
            end_reg <= TOP_IDX;
            auto_unprotect_reg <= start_unprotect;
            busy_out <= 1'b1;
          end else if (start_sect) begin
            state_reg <= FSPG_ST_ERASE;
            busy_out <= 1'b1;
            if (tgt_sector == 2'd0) begin
              ptr_reg <= S0_LO;
              end_reg <= TOP_IDX;
            end else if (tgt_sector == 2'd1) begin
              ptr_reg <= S1_LO;
              end_reg <= S0_LO - IDX_ONE;
            end else begin
              ptr_reg <= '0;
              end_reg <= S1_LO - IDX_ONE;
            end
          end else if (start_prog) begin
            state_reg <= FSPG_ST_PROGRAM;
            ptr_reg <= addr_reg[MEM_AW-1:0];
            busy_out <= 1'b1;
          end
        end
        FSPG_ST_PROGRAM: begin
          state_reg <= FSPG_ST_IDLE;
          busy_out <= 1'b0;
        end
        FSPG_ST_ERASE: begin
          if (ptr_reg == end_reg) begin
            state_reg <= FSPG_ST_IDLE;
            auto_unprotect_reg <= 1'b0;
            busy_out <= 1'b0;
          end else begin
            ptr_reg <= ptr_reg + IDX_ONE;
          end
        end
        default: begin
          state_reg <= FSPG_ST_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // Protection stays on until the unprotect erase has finished
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      protect_reg <= FSPG_OPT_RESET[FSPG_OPT_PROTECT];
    end else if (finish && auto_unprotect_reg) begin
      protect_reg <= 1'b0;
    end else if (opt_write && !protect_reg && state_reg == FSPG_ST_IDLE) begin
      protect_reg <= w_data_reg[FSPG_OPT_PROTECT];
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      readout_protect_out <= 1'b0;
    end else begin
      readout_protect_out <= protect_reg;
    end
  end

  // Sticky flags: a new event beats a write-one clear in the same cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_reg <= FSPG_CTRL_RESET[FSPG_CTL_DONE];
      refused_reg <= FSPG_CTRL_RESET[FSPG_CTL_REFUSED];
    end else begin
      if (finish) begin
        done_reg <= 1'b1;
      end else if (wr_ctrl && w_data_reg[FSPG_CTL_DONE]) begin
        done_reg <= 1'b0;
      end
      if ((cmd_write && !(start_mass || start_sect || start_prog)) ||
          (wr_opt && !opt_write)) begin
        refused_reg <= 1'b1;
      end else if (wr_ctrl && w_data_reg[FSPG_CTL_REFUSED]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Array
  // ----------------------------------------
  assign mem_we = state_reg != FSPG_ST_IDLE;

  fspg_flash_mem #(
    .DEPTH(FLASH_BYTES),
    .AW(MEM_AW)
  ) u_mem (
    .clk_in(sys_clk_in),
    .we_in(mem_we),
    .waddr_in(ptr_reg),
    .wdata_in(state_reg == FSPG_ST_PROGRAM ? wdata_reg : FSPG_ERASED),
    .raddr_in(addr_reg[MEM_AW-1:0]),
    .rdata_out(mem_rdata)
  );

endmodule // fspg_flash_guard

// file: common/fspg_pkg.sv
package fspg_pkg;

  // ----------------------------------------
  // Register map (index, byte = index * 4)
  // ----------------------------------------
  localparam int FSPG_AXI_AW = 12;
  localparam logic [7:0] FSPG_IDX_CTRL = 8'h2b;
  localparam logic [7:0] FSPG_IDX_KEY = 8'h40;
  localparam logic [7:0] FSPG_IDX_ADDR = 8'h41;
  localparam logic [7:0] FSPG_IDX_WDATA = 8'h42;
  localparam logic [7:0] FSPG_IDX_RDATA = 8'h43;
  localparam logic [7:0] FSPG_IDX_OPTION = 8'h44;
  localparam logic [7:0] FSPG_IDX_MODE = 8'h45;

  // ----------------------------------------
  // Control/status fields and reset values
  // ----------------------------------------
  localparam int FSPG_CTL_PROG = 0;
  localparam int FSPG_CTL_SECT_ERASE = 1;
  localparam int FSPG_CTL_MASS_ERASE = 2;
  localparam int FSPG_CTL_REFUSED = 5;
  localparam int FSPG_CTL_DONE = 6;
  localparam int FSPG_CTL_BUSY = 7;
  localparam logic [7:0] FSPG_CTRL_RESET = 8'h00;
  localparam int FSPG_OPT_PROTECT = 0;
  localparam logic [7:0] FSPG_OPT_RESET = 8'h00;
  localparam logic [15:0] FSPG_ADDR_RESET = 16'h0000;
  localparam logic [7:0] FSPG_WDATA_RESET = 8'h00;

  // ----------------------------------------
  // Array layout and guard keys
  // ----------------------------------------
  localparam int FSPG_FLASH_BYTES = 32768;
  localparam int FSPG_SECTOR_BYTES = 4096;
  localparam logic [7:0] FSPG_ERASED = 8'hff;
  localparam logic [7:0] FSPG_KEY_FIRST = 8'h5a;
  localparam logic [7:0] FSPG_KEY_SECOND = 8'ha5;
  localparam logic [1:0] FSPG_RESP_OKAY = 2'b00;
  localparam logic [1:0] FSPG_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    FSPG_MODE_IAP,
    FSPG_MODE_ICP,
    FSPG_MODE_TOOL
  } fspg_mode_t;

  typedef enum logic [1:0] {
    FSPG_ST_IDLE,
    FSPG_ST_PROGRAM,
    FSPG_ST_ERASE
  } fspg_state_t;

endpackage

// file: rtl/fspg_flash_mem.sv
`timescale 1ns/1ps
module fspg_flash_mem #(
  parameter int DEPTH = 32768,
  parameter int AW = 15
) (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [7:0] rdata_out
);

  // Array starts erased, as a blank part would
  logic [7:0] mem [DEPTH] = '{default: 8'hff};

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rdata_out <= mem[raddr_in];
  end

endmodule // fspg_flash_mem

// file: rtl/fspg_access_guard.sv
`timescale 1ns/1ps
module fspg_access_guard import fspg_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic key_wr_in,
  input wire logic [7:0] key_in,
  input wire logic consume_in,
  output logic unlocked_out
);

  logic armed_reg;

  // Two keys back to back unlock one command; any other key write, or a control or option write, relocks
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      armed_reg <= 1'b0;
      unlocked_out <= 1'b0;
    end else if (key_wr_in) begin
      armed_reg <= (key_in == FSPG_KEY_FIRST);
      unlocked_out <= armed_reg && (key_in == FSPG_KEY_SECOND);
    end else if (consume_in) begin
      armed_reg <= 1'b0;
      unlocked_out <= 1'b0;
    end
  end

endmodule // fspg_access_guard

// file: testbench/fspg_prog_tool.sv
`timescale 1ns/1ps
// ----------------------------------------
// External programming controller model
// ----------------------------------------
module fspg_prog_tool (
  input wire logic clk_in,
  input wire logic plug_in,
  input wire logic icc_in,
  output logic attached_out,
  output logic select_out,
  output logic [1:0] pin_out
);
  // Select held before reset release to enter comm mode
  always_ff @(posedge clk_in) begin
    attached_out <= plug_in;
    select_out <= icc_in;
  end
  // Bit 0 changes every cycle and bit 1 every second cycle, so a stale level cannot pass
  // Plain always: the start value comes from the initial block
  always @(posedge clk_in) begin
    pin_out <= pin_out + 2'h1;
  end
  initial pin_out = 2'h0;
endmodule // fspg_prog_tool

// file: testbench/fspg_flash_guard_monitor.sv
`timescale 1ns/1ps
module fspg_flash_guard_monitor import fspg_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic prog_attached_in,
  input wire logic [1:0] prog_pin_in,
  input wire logic [1:0] app_pin_value_out,
  input wire logic [1:0] prog_pin_oe_out,
  input wire logic [1:0] prog_mode_out,
  input wire logic readout_protect_out,
  input wire logic busy_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Straps settle in the first edges, so age gates mode checks
  logic [1:0] age_reg;
  always_ff @(posedge sys_clk_in or posedge rst_in)
    if (rst_in) age_reg <= 2'h0;
    else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
  a_pins_withheld: assert property (
    prog_attached_in |=> app_pin_value_out == 2'h0 && prog_pin_oe_out == 2'h0)
    else $error("pins reach application with tool attached");
  a_pins_follow: assert property (
    age_reg == 2'h3 && !prog_attached_in && prog_mode_out == 2'h0
    |=> app_pin_value_out == $past(prog_pin_in))
    else $error("application pin level does not follow pin");
  a_write_answer: assert property (
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
    s_axi_wready_out |=> !s_axi_awready_out ##1 s_axi_bvalid_out)
    else $error("write response late");
  a_write_ready: assert property (
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("ready high while response pending");
  a_read_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> !s_axi_arready_out ##1
    s_axi_rvalid_out) else $error("read data late");
  a_slverr_zero: assert property (
    s_axi_rvalid_out && s_axi_rresp_out == FSPG_RESP_SLVERR
    |-> s_axi_rdata_out == 32'h0) else $error("error read not zero");
  a_protect_fall: assert property (
    $fell(readout_protect_out) |-> $past(busy_out, 2))
    else $error("protection dropped without erase");
  a_mode_stable: assert property (
    age_reg == 2'h3 |=> $stable(prog_mode_out))
    else $error("mode changed after strap sampling");
  c_unprotect: cover property ($fell(readout_protect_out));
  c_op_end: cover property ($fell(busy_out));
  c_bad_read: cover property (s_axi_rvalid_out && s_axi_rresp_out != 2'h0);
endmodule // fspg_flash_guard_monitor
bind fspg_flash_guard fspg_flash_guard_monitor mon_u (.sys_clk_in, .rst_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
  .s_axi_rresp_out, .s_axi_rdata_out, .prog_attached_in, .prog_pin_in,
  .app_pin_value_out, .prog_pin_oe_out, .prog_mode_out, .readout_protect_out,
  .busy_out);

// file: testbench/fspg_flash_guard_tb.sv
`timescale 1ns/1ps
module fspg_flash_guard_tb import fspg_pkg::*;;
  // Two sectors keep both erase lengths short
  localparam int FB = 8192;
  logic clk = '0;
  logic rst = '1;
  logic [11:0] awa = '0, ara = '0;
  logic awv = '0, wv = '0, arv = '0, plug = '0, in_circuit_comm_mode = '0, tsk = '0;
  logic [1:0] b;
  logic [31:0] wd = '0, d, rd;
  logic [1:0] r, adrv = 2'h1, aoe = 2'h2, brs, rrs, pv, poe, papp, mode, ppin;
  logic awr, wrdy, bvl, arr, rvl, prot, busy, att, sel;
  int err_total = 0, n_compared = 0;
  always #2 clk = ~clk;
  fspg_prog_tool tool_u (.clk_in(clk), .plug_in(plug), .icc_in(in_circuit_comm_mode),
    .attached_out(att), .select_out(sel), .pin_out(ppin));
  fspg_flash_guard #(.FLASH_BYTES(FB)) dut_u (.sys_clk_in(clk), .rst_in(rst),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(brs), .s_axi_bvalid_out(bvl),
    .s_axi_bready_in(1'h1), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rrs),
    .s_axi_rvalid_out(rvl), .s_axi_rready_in(1'h1), .tool_socket_in(tsk),
    .prog_select_voltage_in(sel), .prog_attached_in(att), .prog_pin_in(ppin),
    .app_pin_drive_in(adrv), .app_pin_oe_in(aoe), .prog_pin_out(pv),
    .prog_pin_oe_out(poe), .app_pin_value_out(papp), .prog_mode_out(mode),
    .readout_protect_out(prot), .busy_out(busy));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tmo();
    err_total++;
    $display("wrong value at %0t: wait expired", $time);
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  // Ready lines stay high, so each answer is taken at its first edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int i;
    awa <= a;
    wd <= v;
    awv <= '1;
    wv <= '1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awr) awv <= '0;
      if (wrdy) wv <= '0;
      if (bvl) begin
        b = brs;
        break;
      end
    end
    if (i == 50) tmo();
  endtask
  task automatic rdr(input logic [11:0] a);
    int i;
    ara <= a;
    arv <= '1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arr) arv <= '0;
      if (rvl) break;
    end
    if (i == 50) tmo();
    d = rd;
    r = rrs;
  endtask
  // Waits while busy (p low) or protection (p high) stands
  task automatic wl(input bit p);
    int i;
    for (i = 0; i < 20000 && (p ? prot : busy); i++) @(posedge clk);
    if (i == 20000) tmo();
  endtask
  task automatic unl();
    wr(ba(FSPG_IDX_KEY), {24'h0, FSPG_KEY_FIRST});
    wr(ba(FSPG_IDX_KEY), {24'h0, FSPG_KEY_SECOND});
  endtask
  task automatic rb(input logic [15:0] a);
    wr(ba(FSPG_IDX_ADDR), {16'h0, a});
    rdr(ba(FSPG_IDX_RDATA));
  endtask
  // Clears sticky flags, unlocks, starts, then returns the refused flag (bit 5) in d
  task automatic cmd(input logic [15:0] a, input logic [7:0] b);
    wr(ba(FSPG_IDX_CTRL), 32'h60);
    wr(ba(FSPG_IDX_ADDR), {16'h0, a});
    unl();
    wr(ba(FSPG_IDX_CTRL), {24'h0, b});
    @(posedge clk);
    wl(1'h0);
    rdr(ba(FSPG_IDX_CTRL));
    d = d & 32'h20;
  endtask
  task automatic reset_dut();
    rst <= '1;
    repeat (12) @(posedge clk);
    rst <= '0;
    repeat (3) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    reset_dut();
    rdr(ba(FSPG_IDX_CTRL));
    chk(d, 32'h0);
    rdr(12'hff0);
    chk({30'h0, r}, {30'h0, FSPG_RESP_SLVERR});
    wr(12'hff0, 32'h0);
    chk({30'h0, b}, {30'h0, FSPG_RESP_SLVERR});
    chk({30'h0, pv}, 32'h1);
    chk({30'h0, poe}, 32'h2);
    wr(ba(FSPG_IDX_WDATA), 32'h3c);
    chk({30'h0, b}, {30'h0, FSPG_RESP_OKAY});
    wr(ba(FSPG_IDX_ADDR), 32'he000);
    wr(ba(FSPG_IDX_CTRL), 32'h1);
    rb(16'he000);
    chk(d, 32'hff);
    cmd(16'he000, 8'h01);
    chk(d, 32'h0);
    rb(16'he000);
    chk(d, 32'h3c);
    cmd(16'hf000, 8'h01);
    chk(d, 32'h20);
    cmd(16'hf000, 8'h02);
    chk(d, 32'h20);
    cmd(16'he000, 8'h04);
    chk(d, 32'h20);
    rb(16'hf000);
    chk(d, 32'hff);
    cmd(16'hd000, 8'h01);
    chk(d, 32'h20);
    $display("test app_mode done");
    plug <= '1;
    in_circuit_comm_mode <= '1;
    reset_dut();
    rdr(ba(FSPG_IDX_MODE));
    chk(d, 32'h1);
    chk({30'h0, papp}, 32'h0);
    wr(ba(FSPG_IDX_WDATA), 32'h5a);
    cmd(16'hf000, 8'h01);
    chk(d, 32'h0);
    rb(16'hf000);
    chk(d, 32'h5a);
    cmd(16'he000, 8'h02);
    chk(d, 32'h0);
    rb(16'he000);
    chk(d, 32'hff);
    rb(16'hf000);
    chk(d, 32'h5a);
    unl();
    wr(ba(FSPG_IDX_OPTION), 32'h1);
    @(posedge clk);
    chk({31'h0, prot}, 32'h1);
    cmd(16'he000, 8'h01);
    chk(d, 32'h20);
    rb(16'hf000);
    chk(d, 32'h0);
    unl();
    wr(ba(FSPG_IDX_OPTION), 32'h0);
    wl(1'h1);
    rb(16'hf000);
    chk(d, 32'hff);
    $display("test icp_mode done");
    plug <= '0;
    in_circuit_comm_mode <= '0;
    tsk <= '1;
    reset_dut();
    rdr(ba(FSPG_IDX_MODE));
    chk(d, 32'h2);
    wr(ba(FSPG_IDX_WDATA), 32'h77);
    cmd(16'hf000, 8'h01);
    chk(d, 32'h0);
    rb(16'hf000);
    chk(d, 32'h77);
    cmd(16'he000, 8'h04);
    chk(d, 32'h0);
    rb(16'hf000);
    chk(d, 32'hff);
    $display("test tool_mode done");
    print_verdict();
  end
endmodule // fspg_flash_guard_tb
